/* bsl_top.sv */
// Purpose : Boundary-scan data path, instruction register, reset data
//           register and the two software registers behind the test port.
// Assumes : TAP state flags come from an external controller on the test
//           clock; all of them and the test clock are sampled by clk_sys.
// Notes   : clk_sys must run well above the test clock (>= 8x).
// Operation
// - Opcode 2 routes scan chain, system untouched
// - Sample: capture pins, shift one per clock
// - Update fills latches, never drives pins
// - Opcode C selects one-bit reset register
// - Reset held unlatched while bit is one
// - Opcode F selects single bypass stage
// - Bypass captures zero, then shifts
// - Disable bit off plus fuse enables port
// - Disable bit changes on two writes
// - Test-reset flag set by reset register
// - Flag cleared by power-on or zero write
// - Pin: pull-up cell plus two-stage cell
// - Cells follow port, direction, raw pin
// - Pull-up cell sees product of three terms
// - Chain observes real pin, after alternates
// - Reset pin: two observe-only cells
// - Oscillator enable general, clock observe-only
// - Unused clock lines read fixed values
// - Comparator off, mux, bandgap, output cells
// - Four-bit IR, LSB first everywhere
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps

module bsl_top #(
   parameter int NPIN        = 8,    // Scanned bidirectional pins
   parameter bit EXCK_USED   = 1'b1, // External clock option in use
   parameter bit OSCK_USED   = 1'b0, // Crystal/resonator option in use
   parameter bit LFCK_USED   = 1'b0  // Low-frequency crystal option in use
) (
   // Clock and reset
   input  wire logic                       clk_sys,
   input  wire logic                       srst,
   // Test port pins and TAP state flags
   input  wire logic                       tck,
   input  wire logic                       tdi,
   input  wire logic                       tap_capture_ir,
   input  wire logic                       tap_shift_ir,
   input  wire logic                       tap_update_ir,
   input  wire logic                       tap_capture_dr,
   input  wire logic                       tap_shift_dr,
   input  wire logic                       tap_update_dr,
   output logic                            tdo,
   output logic                            tdo_oe,
   // Fuse and port enable
   input  wire logic                       test_port_enable_fuse,
   output logic                            test_port_enable,
   // Port pins as seen after the alternate-function muxes
   input  wire logic [NPIN-1:0]            pin_output_bit,
   input  wire logic [NPIN-1:0]            pin_direction_bit,
   input  wire logic [NPIN-1:0]            pin_input_value,
   input  wire logic                       global_pullup_disable,
   // Reset pin levels
   input  wire logic                       reset_pin_n,
   input  wire logic                       hv_reset_pin,
   // Oscillator enables and clock lines
   input  wire logic                       ext_clock_enable,
   input  wire logic                       ext_clock_line,
   input  wire logic                       crystal_osc_enable,
   input  wire logic                       crystal_osc_clock,
   input  wire logic                       lowfreq_osc_enable,
   input  wire logic                       lowfreq_osc_clock,
   // Comparator interface
   input  wire logic                       comparator_off,
   input  wire logic                       comparator_mux_select,
   input  wire logic                       comparator_bandgap_enable,
   input  wire logic                       comparator_output,
   // Scan and register results toward the chip
   output logic [3*NPIN+11:0]              preload_latch,
   output logic                            chip_reset,
   output logic [6:0]                      mcu_ctl_bits,
   // Register port
   input  wire logic [bsl_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]                 reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic [7:0]                      reg_rdata
);

   localparam int PIN_CELLS = bsl_pkg::CELLS_PER_PIN * NPIN;
   localparam int CL        = PIN_CELLS + bsl_pkg::N_FIXED;

   typedef struct packed {
      logic [bsl_pkg::NSYNC-1:0] s1;        // First synchroniser stage
      logic [bsl_pkg::NSYNC-1:0] s2;        // Second synchroniser stage
      logic                      tck_d;     // Previous synced test clock
      logic [3:0]                ir_sh;     // Instruction shift stage
      logic [3:0]                ir;        // Active instruction
      logic [CL-1:0]             bs;        // Boundary-scan shift chain
      logic [CL-1:0]             latch;     // Preload latches
      logic                      byp;       // Bypass stage
      logic                      rdr;       // Reset data register
      logic                      tdo;
      logic                      tdo_oe;
      logic                      dis;       // test_port_disable_bit
      logic [6:0]                ctl_lo;    // Other mcu_control bits
      logic                      pend_v;    // Value of first timed write
      logic [2:0]                pend_cnt;  // Window left for second write
      logic                      trf;       // test_reset_flag
      logic [7:0]                rdata;
   } bsl_st_t;

   bsl_st_t                 st_r;
   bsl_st_t                 st_nxt;
   logic [bsl_pkg::NSYNC-1:0] async_in;
   logic [CL-1:0]           cap;
   logic [bsl_pkg::N_FIXED-1:0] cap_fix;   // Fixed cells, one driver apart from the pins
   logic                    tck_rise;
   logic                    tck_fall;
   logic                    port_en;
   bsl_pkg::bsl_dr_t        dsel;

   ////////////////////////////////////////////////////////////////////////////
   // Inputs from outside clk_sys, gathered for the two-flop synchroniser
   always_comb
   begin
      async_in                        = '0;
      async_in[bsl_pkg::S_TCK]        = tck;
      async_in[bsl_pkg::S_TDI]        = tdi;
      async_in[bsl_pkg::S_CIR]        = tap_capture_ir;
      async_in[bsl_pkg::S_SIR]        = tap_shift_ir;
      async_in[bsl_pkg::S_UIR]        = tap_update_ir;
      async_in[bsl_pkg::S_CDR]        = tap_capture_dr;
      async_in[bsl_pkg::S_SDR]        = tap_shift_dr;
      async_in[bsl_pkg::S_UDR]        = tap_update_dr;
      async_in[bsl_pkg::S_RSTN]       = reset_pin_n;
      async_in[bsl_pkg::S_HVR]        = hv_reset_pin;
      async_in[bsl_pkg::S_EXCK]       = ext_clock_line;
      async_in[bsl_pkg::S_OSCK]       = crystal_osc_clock;
      async_in[bsl_pkg::S_LFCK]       = lowfreq_osc_clock;
      async_in[bsl_pkg::S_ACO]        = comparator_output;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Capture values for the port-pin cells, one group per pin
   for (genvar i = 0; i < NPIN; i++)
   begin : g_pin
      localparam int B = bsl_pkg::CELLS_PER_PIN * i;
      // Pull-up enable as the pin would see it
      assign cap[B + bsl_pkg::C_PU]  = ~global_pullup_disable & ~pin_direction_bit[i]
                                       & pin_output_bit[i];
      assign cap[B + bsl_pkg::C_OC]  = pin_direction_bit[i];
      // Raw pin level: no synchroniser, so a pin moving at capture may
      // be caught either way; the scan result is a snapshot only
      assign cap[B + bsl_pkg::C_DAT] = pin_input_value[i];
   end

   // Fixed cells after the pins; kept in their own vector so that the
   // capture word never mixes procedural and continuous drivers
   always_comb
   begin
      cap_fix                   = '0;
      cap_fix[bsl_pkg::F_NORMAL_RESET_OBSERVE]  = st_r.s2[bsl_pkg::S_RSTN];
      cap_fix[bsl_pkg::F_HV_RESET_OBSERVE] = st_r.s2[bsl_pkg::S_HVR];
      cap_fix[bsl_pkg::F_EXEN]  = ext_clock_enable;
      cap_fix[bsl_pkg::F_OSEN]  = crystal_osc_enable;
      cap_fix[bsl_pkg::F_LFEN]  = lowfreq_osc_enable;
      // Unused clock options read their fixed level
      cap_fix[bsl_pkg::F_EXCK]  = EXCK_USED ? st_r.s2[bsl_pkg::S_EXCK]
                                            : bsl_pkg::EXCK_UNUSED;
      cap_fix[bsl_pkg::F_OSCK]  = OSCK_USED ? st_r.s2[bsl_pkg::S_OSCK]
                                            : bsl_pkg::OSCK_UNUSED;
      cap_fix[bsl_pkg::F_LFCK]  = LFCK_USED ? st_r.s2[bsl_pkg::S_LFCK]
                                            : bsl_pkg::LFCK_UNUSED;
      cap_fix[bsl_pkg::F_ACOFF] = comparator_off;
      cap_fix[bsl_pkg::F_ACMUX] = comparator_mux_select;
      cap_fix[bsl_pkg::F_COMPARATOR_BANDGAP_ENABLE]  = comparator_bandgap_enable;
      cap_fix[bsl_pkg::F_ACO]   = st_r.s2[bsl_pkg::S_ACO];
   end

   // Fixed cells sit directly after the last pin group
   assign cap[PIN_CELLS +: bsl_pkg::N_FIXED] = cap_fix;

   ////////////////////////////////////////////////////////////////////////////
   // Test clock edges and port enable
   assign tck_rise = st_r.s2[bsl_pkg::S_TCK] & ~st_r.tck_d;
   assign tck_fall = ~st_r.s2[bsl_pkg::S_TCK] & st_r.tck_d;
   assign port_en  = test_port_enable_fuse & ~st_r.dis;
   assign dsel     = bsl_pkg::dr_sel(st_r.ir);

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      st_nxt       = st_r;
      st_nxt.s1    = async_in;
      st_nxt.s2    = st_r.s1;
      st_nxt.tck_d = st_r.s2[bsl_pkg::S_TCK];
      st_nxt.rdata = '0;

      // Scan actions on the test clock rising edge
      if (port_en && tck_rise)
      begin
         if (st_r.s2[bsl_pkg::S_CIR])
         begin
            st_nxt.ir_sh = bsl_pkg::IR_CAPTURE;
         end
         if (st_r.s2[bsl_pkg::S_SIR])
         begin
            st_nxt.ir_sh = {st_r.s2[bsl_pkg::S_TDI], st_r.ir_sh[3:1]};
         end
         if (st_r.s2[bsl_pkg::S_UIR])
         begin
            st_nxt.ir = st_r.ir_sh;
         end
         if (st_r.s2[bsl_pkg::S_CDR])
         begin
            unique case (dsel)
               bsl_pkg::DR_BSC: st_nxt.bs  = cap;
               bsl_pkg::DR_BYP: st_nxt.byp = 1'b0;
               bsl_pkg::DR_RST: st_nxt.rdr = st_r.rdr;
            endcase
         end
         if (st_r.s2[bsl_pkg::S_SDR])
         begin
            unique case (dsel)
               bsl_pkg::DR_BSC: st_nxt.bs  = {st_r.s2[bsl_pkg::S_TDI],
                                              st_r.bs[CL-1:1]};
               bsl_pkg::DR_BYP: st_nxt.byp = st_r.s2[bsl_pkg::S_TDI];
               bsl_pkg::DR_RST: st_nxt.rdr = st_r.s2[bsl_pkg::S_TDI];
            endcase
         end
         // Latches only; nothing here reaches the pin drivers
         if (st_r.s2[bsl_pkg::S_UDR] && dsel == bsl_pkg::DR_BSC)
         begin
            st_nxt.latch = st_r.bs;
         end
      end

      // Serial output changes on the falling edge, LSB first
      if (port_en && tck_fall)
      begin
         // The fall after a capture edge already belongs to the shift
         // phase, so the captured bit 0 must be presented there
         st_nxt.tdo_oe = st_r.s2[bsl_pkg::S_CIR] | st_r.s2[bsl_pkg::S_SIR]
                         | st_r.s2[bsl_pkg::S_CDR] | st_r.s2[bsl_pkg::S_SDR];
         if (st_r.s2[bsl_pkg::S_CIR] || st_r.s2[bsl_pkg::S_SIR])
         begin
            st_nxt.tdo = st_r.ir_sh[0];
         end
         else
         begin
            unique case (dsel)
               bsl_pkg::DR_BSC: st_nxt.tdo = st_r.bs[0];
               bsl_pkg::DR_BYP: st_nxt.tdo = st_r.byp;
               bsl_pkg::DR_RST: st_nxt.tdo = st_r.rdr;
            endcase
         end
      end
      if (!port_en)
      begin
         st_nxt.tdo_oe = 1'b0;
      end

      // Timed write window counts down each cycle
      if (st_r.pend_cnt != '0)
      begin
         st_nxt.pend_cnt = st_r.pend_cnt - 3'h1;
      end

      // Register writes
      if (reg_wr && reg_addr == bsl_pkg::ADR_MCU_CTL)
      begin
         st_nxt.ctl_lo = reg_wdata[6:0];
         // Second matching write inside the window commits the bit
         if (st_r.pend_cnt != '0 && st_r.pend_v == reg_wdata[bsl_pkg::DIS_BIT])
         begin
            st_nxt.dis      = reg_wdata[bsl_pkg::DIS_BIT];
            st_nxt.pend_cnt = '0;
         end
         else
         begin
            st_nxt.pend_v   = reg_wdata[bsl_pkg::DIS_BIT];
            st_nxt.pend_cnt = bsl_pkg::DIS_WIN;
         end
      end
      if (reg_wr && reg_addr == bsl_pkg::ADR_RST_STAT && !reg_wdata[bsl_pkg::TRF_BIT])
      begin
         st_nxt.trf = 1'b0;
      end
      // Set wins over a clear in the same cycle
      if (st_r.rdr)
      begin
         st_nxt.trf = 1'b1;
      end

      // Register reads, data valid the following cycle only
      if (reg_rd)
      begin
         if (reg_addr == bsl_pkg::ADR_MCU_CTL)
         begin
            st_nxt.rdata = {st_r.dis, st_r.ctl_lo};
         end
         else if (reg_addr == bsl_pkg::ADR_RST_STAT)
         begin
            st_nxt.rdata                   = bsl_pkg::RST_STAT_RST;
            st_nxt.rdata[bsl_pkg::TRF_BIT] = st_r.trf;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; srst stands in for power-on reset
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         st_r          <= '0;
         st_r.ir       <= bsl_pkg::IR_RST_VAL;
         st_r.ir_sh    <= bsl_pkg::IR_RST_VAL;
         st_r.s1       <= '0;
         st_r.trf      <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs; chip reset is the raw register bit, never re-latched, and it
   // does not reset this block, so the test port keeps its state
   assign chip_reset       = st_r.rdr;
   assign tdo              = st_r.tdo;
   assign tdo_oe           = st_r.tdo_oe;
   assign test_port_enable = port_en;
   assign preload_latch    = st_r.latch;
   assign mcu_ctl_bits     = st_r.ctl_lo;
   assign reg_rdata        = st_r.rdata;

endmodule : bsl_top

/* bsl_pkg.sv */
// Purpose : Shared constants and types for the boundary-scan test logic.
// Assumes : Four-bit instruction register, LSB shifted first.
// Notes   : Fixed-cell offsets are relative to the end of the port-pin section; pin-cell offsets to each pin group.
package bsl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction register
   localparam int          IR_W         = 4;
   localparam logic [3:0]  OP_SAMPLE    = 4'h2;   // Sample/preload
   localparam logic [3:0]  OP_CHIP_RST  = 4'hc;   // Chip-reset instruction
   localparam logic [3:0]  OP_BYPASS    = 4'hf;   // Bypass
   localparam logic [3:0]  IR_CAPTURE   = 4'h1;   // Fixed pattern in Capture-IR
   localparam logic [3:0]  IR_RST_VAL   = 4'hf;   // Active code after reset

   ////////////////////////////////////////////////////////////////////////////
   // Register port
   localparam int          ADDR_W       = 2;
   localparam logic [1:0]  ADR_MCU_CTL  = 2'h0;   // mcu_control
   localparam logic [1:0]  ADR_RST_STAT = 2'h1;   // reset_cause_status
   localparam int          DIS_BIT      = 7;      // test_port_disable_bit
   localparam int          TRF_BIT      = 4;      // test_reset_flag
   localparam logic [2:0]  DIS_WIN      = 3'h4;   // Cycles for second write
   localparam logic [7:0]  RST_STAT_RST = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Synchroniser lanes (inputs from outside clk_sys)
   localparam int S_TCK  = 0;
   localparam int S_TDI  = 1;
   localparam int S_CIR  = 2;
   localparam int S_SIR  = 3;
   localparam int S_UIR  = 4;
   localparam int S_CDR  = 5;
   localparam int S_SDR  = 6;
   localparam int S_UDR  = 7;
   localparam int S_RSTN = 8;
   localparam int S_HVR  = 9;
   localparam int S_EXCK = 10;
   localparam int S_OSCK = 11;
   localparam int S_LFCK = 12;
   localparam int S_ACO  = 13;
   localparam int NSYNC  = 14;

   ////////////////////////////////////////////////////////////////////////////
   // Chain layout: per pin three cells, then the fixed cells
   localparam int CELLS_PER_PIN = 3;
   localparam int C_PU          = 0;   // Pull-up enable cell
   localparam int C_OC          = 1;   // Output control stage
   localparam int C_DAT         = 2;   // Output data / input data stage
   localparam int F_NORMAL_RESET_OBSERVE        = 0;
   localparam int F_HV_RESET_OBSERVE       = 1;
   localparam int F_EXEN        = 2;
   localparam int F_EXCK        = 3;
   localparam int F_OSEN        = 4;
   localparam int F_OSCK        = 5;
   localparam int F_LFEN        = 6;
   localparam int F_LFCK        = 7;
   localparam int F_ACOFF       = 8;
   localparam int F_ACMUX       = 9;
   localparam int F_COMPARATOR_BANDGAP_ENABLE        = 10;
   localparam int F_ACO         = 11;
   localparam int N_FIXED       = 12;

   // Scanned clock line when its option is unused
   localparam logic EXCK_UNUSED = 1'b0;
   localparam logic OSCK_UNUSED = 1'b1;
   localparam logic LFCK_UNUSED = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // Data register selection
   typedef enum logic [1:0]
   {
      DR_BYP = 2'b00,
      DR_BSC = 2'b01,
      DR_RST = 2'b11
   } bsl_dr_t;

   // Any unused opcode falls back to the bypass stage
   function automatic bsl_dr_t dr_sel(input logic [3:0] ir);
      bsl_dr_t d;
      d = DR_BYP;
      if (ir == OP_SAMPLE)
      begin
         d = DR_BSC;
      end
      else if (ir == OP_CHIP_RST)
      begin
         d = DR_RST;
      end
      return d;
   endfunction : dr_sel

endpackage : bsl_pkg

/* bsl_tap_ctl.sv */
// Purpose : Board-level test controller driving the test link of bsl_top.
// Assumes : clk_sys runs 48 times per test clock (240 ns period).
// Notes   : Test clock stands low between steps; flags change mid-low.
`timescale 1ns/1ps

module bsl_tap_ctl (
   // System clock and serial return
   input  wire logic       clk_sys,
   input  wire logic       tdo,
   // Test link toward the device
   output logic            tck,
   output logic            tdi,
   output logic [5:0]      tap_st
);

   // Quiet link until the bench starts a frame
   initial
   begin
      tck = 1'b0;
      tdi = 1'b0;
      tap_st = 6'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One test-clock period; flags settle 16 clk_sys cycles before the rise
   task automatic step(input logic [5:0] st, input logic d, output logic q);
      @(posedge clk_sys);
      tap_st <= st;
      tdi <= d;
      repeat (16) @(posedge clk_sys);
      tck <= 1'b1;
      repeat (16) @(posedge clk_sys);
      tck <= 1'b0;
      repeat (15) @(posedge clk_sys);
      q = tdo;
   endtask : step

   // Capture, n shifts with LSB first, update; tdo bits are returned
   task automatic scan(input logic ir, input int n, input logic [63:0] din,
                       output logic [63:0] dout);
      logic q;
      dout = '0;
      step(ir ? 6'h01 : 6'h08, ~din[0], q);
      for (int i = 0; i < n; i++)
      begin
         dout[i] = q;
         step(ir ? 6'h02 : 6'h10, din[i], q);
      end
      step(ir ? 6'h04 : 6'h20, ~q, q);
   endtask : scan

endmodule : bsl_tap_ctl

/* bsl_top_chk.sv */
// Purpose : Port-level assertions for bsl_top.
// Assumes : One clk_sys domain with synchronous srst.
// Notes   : Test-link relations rest on the short synchroniser delay.
`timescale 1ns/1ps

module bsl_top_chk #(
   parameter int NPIN = 8
) (
   // Clock, reset and test link
   input wire logic clk_sys, srst, tck, tdo, tdo_oe, tap_shift_dr, tap_update_dr,
   // Enable and chip side
   input wire logic test_port_enable_fuse, test_port_enable, chip_reset,
   input wire logic [3*NPIN+11:0] preload_latch,
   input wire logic [6:0] mcu_ctl_bits,
   // Register port
   input wire logic [bsl_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata, reg_rdata,
   input wire logic reg_wr, reg_rd
);

   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);

   ////////////////////////////////////////////////////////////////////////////
   // Lone disable write framed by quiet cycles, so no pairing can occur
   sequence s_lone_dis;
      !reg_wr [*4] ##1 reg_wr && reg_addr == 2'h0 && reg_wdata[7] && test_port_enable
      ##1 !reg_wr [*5];
   endsequence

   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its slot");
   a_unmapped_rd: assert property (reg_rd && reg_addr > 2'h1 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_ctl_bits: assert property (reg_wr && reg_addr == 2'h0 |=>
      {1'b0, mcu_ctl_bits} == ($past(reg_wdata) & 8'h7f)) else $error("control bits lost");
   a_fuse_gate: assert property (test_port_enable |-> test_port_enable_fuse)
      else $error("port enabled without fuse");
   a_oe_gated: assert property (!test_port_enable && !$past(test_port_enable) |-> !tdo_oe)
      else $error("tdo driven while disabled");
   a_en_cause: assert property ($changed(test_port_enable) &&
      $stable(test_port_enable_fuse) |-> $past(reg_wr)) else $error("enable changed without write");
   a_lone_write: assert property (s_lone_dis |-> test_port_enable)
      else $error("single write changed disable bit");
   a_reset_shift: assert property ($changed(chip_reset) |-> tap_shift_dr)
      else $error("chip reset moved outside shift");
   a_latch_update: assert property ($changed(preload_latch) |-> tap_update_dr)
      else $error("latches moved outside update");
   a_tdo_on_fall: assert property ($changed(tdo) |-> !tck)
      else $error("tdo changed while test clock high");

endmodule : bsl_top_chk

bind bsl_top bsl_top_chk #(.NPIN(NPIN)) u_chk (.clk_sys, .srst, .tck, .tdo, .tdo_oe,
   .tap_shift_dr, .tap_update_dr, .test_port_enable_fuse, .test_port_enable, .chip_reset,
   .preload_latch, .mcu_ctl_bits, .reg_addr, .reg_wdata, .reg_rdata, .reg_wr, .reg_rd);

/* bsl_top_tb.sv */
// Purpose : Self-checking bench for bsl_top with a test-controller model.
// Assumes : Two scanned pins keep the chain short.
// Notes   : Expected chain contents are rebuilt from the port inputs.
`timescale 1ns/1ps

module bsl_top_tb;
   localparam int NP = 2;
   localparam int L = 3 * NP + 12;
   logic clk_sys = 1'b0, srst = 1'b1, fuse = 1'b1, gpd = 1'b0;
   logic tck, tdi, tdo, tdo_oe, en, chip_reset, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [5:0] st;
   logic [NP-1:0] po = '0, dir = '0, pin = '0;
   logic [11:0] sig = 12'h101;
   logic [L-1:0] pl;
   logic [6:0] cb;
   logic [bsl_pkg::ADDR_W-1:0] reg_addr = '0;
   logic [7:0] reg_wdata = '0, reg_rdata;
   logic [63:0] v, q, e;
   logic [31:0] r, seed = 32'hd5f5;
   int checks = 0, n_fail = 0;

   always #2.5 clk_sys = ~clk_sys;

   bsl_tap_ctl u_ctl (.clk_sys(clk_sys), .tdo(tdo), .tck(tck), .tdi(tdi), .tap_st(st));

   bsl_top #(.NPIN(NP)) dut (.clk_sys(clk_sys), .srst(srst), .tck(tck), .tdi(tdi),
      .tap_capture_ir(st[0]), .tap_shift_ir(st[1]), .tap_update_ir(st[2]),
      .tap_capture_dr(st[3]), .tap_shift_dr(st[4]), .tap_update_dr(st[5]),
      .tdo(tdo), .tdo_oe(tdo_oe), .test_port_enable_fuse(fuse), .test_port_enable(en),
      .pin_output_bit(po), .pin_direction_bit(dir), .pin_input_value(pin),
      .global_pullup_disable(gpd), .reset_pin_n(sig[0]), .hv_reset_pin(sig[1]),
      .ext_clock_enable(sig[2]), .ext_clock_line(sig[3]), .crystal_osc_enable(sig[4]),
      .crystal_osc_clock(sig[5]), .lowfreq_osc_enable(sig[6]), .lowfreq_osc_clock(sig[7]),
      .comparator_off(sig[8]), .comparator_mux_select(sig[9]),
      .comparator_bandgap_enable(sig[10]), .comparator_output(sig[11]),
      .preload_latch(pl), .chip_reset(chip_reset), .mcu_ctl_bits(cb), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   ////////////////////////////////////////////////////////////////////////////
   // Xorshift source, fixed start
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic cmp(input string nm, input logic [63:0] x, input logic [63:0] g);
      checks++;
      if (g !== x)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, x, g);
      end
   endtask : cmp

   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : idle

   // Register cycles start just after a rising edge
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [1:0] a, input logic [7:0] x);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 cmp("rdata", x, reg_rdata);
      @(posedge clk_sys);
   endtask : rd

   task automatic summarize();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      idle(3);
      srst <= 1'b0;
      idle(3);
      rd(2'h0, 8'h00);
      rd(2'h1, 8'h00);
      rd(2'h2, 8'h00);
      cmp("enable", 64'h1, en);
      v = rnd() | 32'h80; // Last bit one, so a later capture must clear it
      u_ctl.scan(1'b0, 8, v, q);
      cmp("bypass", {v[6:0], 1'b0}, q);
      u_ctl.scan(1'b1, 4, 64'h2, q);
      cmp("ir_capture", 64'h1, q);
      // Random pins, one main clock enable at a time
      r = rnd();
      po <= r[1:0];
      dir <= r[3:2];
      pin <= r[5:4];
      gpd <= r[6];
      sig <= r[27:16] & 12'hfab | 12'h004 << (2 * (r[9:8] % 3));
      @(posedge clk_sys);
      e = '0;
      for (int i = 0; i < NP; i++)
         e[3*i +: 3] = {pin[i], dir[i], ~gpd & ~dir[i] & po[i]};
      e[3*NP +: 12] = sig | 12'h0a0;
      v = {rnd(), rnd()};
      u_ctl.scan(1'b0, L, v, q);
      cmp("capture", e, q);
      cmp("latch", v & ((64'h1 << L) - 1), pl);
      // Chip-reset register holds the chip while it carries a one
      u_ctl.scan(1'b1, 4, 64'hc, q);
      u_ctl.scan(1'b0, 1, 64'h1, q);
      cmp("chip_reset", 64'h1, chip_reset);
      rd(2'h1, 8'h10);
      u_ctl.scan(1'b0, 1, 64'h0, q);
      cmp("reset_bit", 64'h1, q);
      cmp("chip_reset", 64'h0, chip_reset);
      rd(2'h1, 8'h10);
      wr(2'h1, 8'hef);
      rd(2'h1, 8'h00);
      wr(2'h1, 8'h10);
      rd(2'h1, 8'h00);
      // Timed disable: a late second write only re-arms
      wr(2'h0, 8'h85);
      idle(4);
      wr(2'h0, 8'h85);
      idle(6);
      cmp("enable", 64'h1, en);
      cmp("ctl_bits", 64'h5, cb);
      wr(2'h0, 8'h80);
      idle(3);
      wr(2'h0, 8'h80);
      idle(1);
      cmp("enable", 64'h0, en);
      rd(2'h0, 8'h80);
      u_ctl.scan(1'b0, 2, 64'h3, q);
      cmp("chip_reset", 64'h0, chip_reset);
      wr(2'h0, 8'h00);
      idle(1);
      wr(2'h0, 8'h00);
      idle(1);
      cmp("enable", 64'h1, en);
      // Explicit bypass opcode; the stage still holds a one from before
      u_ctl.scan(1'b1, 4, 64'hf, q);
      cmp("ir_capture", 64'h1, q);
      u_ctl.scan(1'b0, 8, v, q);
      cmp("bypass", {v[6:0], 1'b0}, q);
      fuse <= 1'b0;
      @(posedge clk_sys);
      #1 cmp("enable", 64'h0, en);
      @(posedge clk_sys);
      fuse <= 1'b1;
      idle(2);
      summarize();
   end

   // Watchdog well beyond the expected run
   initial
   begin
      #200000;
      n_fail++;
      summarize();
   end

endmodule : bsl_top_tb
